// >>> gpb_board_model.sv
// board circuitry hung on the eight port pins
module gpb_board_model
(
    input wire logic ref_clk,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pullupEn,
    input wire logic [7:0] extDrv,
    input wire logic [7:0] extEn,
    output logic [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // pin levels
    // ----------------------------------------------------------------
    // a pin nobody drives or pulls wanders: it flips every cycle, so a stale
    // value never passes for a real one
    logic [7:0] floatLvl = 8'h00;

    // wander register for undriven pins
    always @(posedge ref_clk)
    begin
        floatLvl <= ~pinIn;
    end

    // the port wins over the board; the board wins over the pull-up
    assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extDrv) | (~pinOe & ~extEn & pullupEn)
                 | (~pinOe & ~extEn & ~pullupEn & floatLvl);
endmodule

// >>> gpb_pin_cell.sv
// per-pin control cell: direction, pull-up and shared-function muxing
module gpb_pin_cell #(
    parameter bit INPUT_ONLY = 1'b0
) (
    input wire logic dirBit,
    input wire logic pullBit,
    input wire logic dataBit,
    input wire logic altEn,
    input wire logic altVal,
    output logic drive,
    output logic driveEn,
    output logic pullEn
);

    // ----------------------------------------------------------------
    // output selection
    // ----------------------------------------------------------------
    // an input-only pin never drives and has no pull-up at all
    always_comb
    begin
        if (INPUT_ONLY)
        begin
            drive = 1'b0;
            driveEn = 1'b0;
            pullEn = 1'b0;
        end
        else if (altEn)
        begin
            // shared function owns the pin and forces it to output
            drive = altVal;
            driveEn = 1'b1;
            pullEn = 1'b0;
        end
        else
        begin
            drive = dataBit;
            driveEn = dirBit;
            // pull-up only helps an input; an output would fight it
            pullEn = pullBit & ~dirBit;
        end
    end

endmodule

// >>> gpb_pkg.sv
// constants and types shared by the general-purpose port bank
package gpb_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_P0_DIR = 10'h0b8; // port0_direction
    localparam logic [9:0] IDX_P1_DIR = 10'h0c1; // port1_direction
    localparam logic [9:0] IDX_P2_DIR = 10'h0c2; // port2_direction
    localparam logic [9:0] IDX_P5_DIR = 10'h0c5; // port5_direction
    localparam logic [9:0] IDX_P0_DATA = 10'h0d0; // port0_data
    localparam logic [9:0] IDX_P1_DATA = 10'h0d1; // port1_data
    localparam logic [9:0] IDX_P2_DATA = 10'h0d2; // port2_data
    localparam logic [9:0] IDX_P5_DATA = 10'h0d5; // port5_data
    localparam logic [9:0] IDX_P0_PULL = 10'h0e0; // port0_pullup, write only
    localparam logic [9:0] IDX_P1_PULL = 10'h0e1; // port1_pullup, write only
    localparam logic [9:0] IDX_P2_PULL = 10'h0e2; // port2_pullup, write only
    localparam logic [9:0] IDX_P5_PULL = 10'h0e5; // port5_pullup, write only
    localparam logic [9:0] IDX_DIR_BITOP = 10'h0f0; // single-bit direction set/clear

    // ----------------------------------------------------------------
    // field layout of the bit-operation register
    // ----------------------------------------------------------------
    localparam int BITOP_SEL_LSB = 0; // pin number, three bits
    localparam int BITOP_VAL_POS = 7; // new direction value

    // ----------------------------------------------------------------
    // pin map: pin number -> port and bit inside that port
    // ----------------------------------------------------------------
    localparam int NUM_PINS = 8;
    localparam logic [1:0] PORT_P0 = 2'h0;
    localparam logic [1:0] PORT_P1 = 2'h1;
    localparam logic [1:0] PORT_P2 = 2'h2;
    localparam logic [1:0] PORT_P5 = 2'h3;
    // pins 0..7: p0.0, p1.0, p1.1, p1.2, p1.3, p2.0, p2.1, p5.4
    localparam logic [7:0][1:0] PIN_PORT = {2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0};
    localparam logic [7:0][2:0] PIN_BIT = {3'h4, 3'h1, 3'h0, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
    localparam int INPUT_ONLY_PIN = 2; // shared with the external reset
    localparam int IRQ_PIN = 0; // shared with the external interrupt input
    localparam int ALT_PIN = 7; // shared with buzzer and pulse-width output

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // register kinds reached by a bus access
    typedef enum logic [2:0] {
        KIND_NONE = 3'b000,
        KIND_DIR = 3'b001,
        KIND_DATA = 3'b010,
        KIND_PULL = 3'b011,
        KIND_BITOP = 3'b100
    } gpb_kind_e;

    // decoded bus address
    typedef struct packed {
        gpb_kind_e kind;
        logic [1:0] port;
    } gpb_decode_s;

    // all state of the port bank
    typedef struct packed {
        logic [7:0] dir; // per-pin direction, 1 = output
        logic [7:0] pull; // per-pin pull-up request
        logic [7:0] data; // per-pin output latch
        logic ready; // bus answer
        logic slvErr; // bus error answer
        logic [31:0] rdata; // bus read data
        logic [7:0] out; // pin output level
        logic [7:0] oe; // pin output enable
        logic [7:0] pu; // pin pull-up enable
        logic irqLevel; // level passed to the interrupt logic
    } gpb_state_s;

endpackage

// >>> gpb_port_bank.sv
// general-purpose port bank with apb register access
//
// Summary of operation
// - eight pins over ports 0, 1, 2, 5
// - direction bit 0 input, 1 output
// - pull-up bit 0 off, 1 on
// - pull-up acts only in input mode
// - input-only pin never driven, direction bit ignored
// - input-only pin has no pull-up
// - reset option selected: input-only bit reads 1
// - data read returns current pin levels
// - data write sets levels of output pins
// - single-bit direction set and clear supported
// - timer outputs off: shared pin is plain gpio
//
// The APB interface to the registers was left to the implementer.
module gpb_port_bank (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    output logic [7:0] pullupEn,
    input wire logic extResetSel,
    input wire logic extIrqEnable,
    output logic extIrqInput,
    input wire logic counterEnable,
    input wire logic toggleOutEnable,
    input wire logic pwmOutEnable,
    input wire logic timerOut
);

    // ----------------------------------------------------------------
    // state and pin cells
    // ----------------------------------------------------------------
    gpb_pkg::gpb_state_s stReg; // registered state
    gpb_pkg::gpb_state_s stNext; // next state
    gpb_pkg::gpb_decode_s dec; // decoded address
    logic [7:0] cellDrive; // pin cell output level
    logic [7:0] cellOe; // pin cell output enable
    logic [7:0] cellPu; // pin cell pull-up
    logic [7:0] pinLevel; // level seen by software
    logic [7:0] altEnVec; // shared-function enable per pin
    logic altActive; // shared pin taken by the timer
    logic accessPhase; // apb access phase

    // shared pin goes to the timer while its toggle or pwm output runs
    assign altActive = pwmOutEnable | (counterEnable & toggleOutEnable);
    assign altEnVec = {altActive, 7'h00};
    assign accessPhase = psel & penable;

    // one cell per pin, the input-only pin gets the reduced cell
    genvar gi;
    generate
        for (gi = 0; gi < gpb_pkg::NUM_PINS; gi++)
        begin : g_pin
            gpb_pin_cell #(
                .INPUT_ONLY(gi == gpb_pkg::INPUT_ONLY_PIN)
            ) u_cell (
                .dirBit(stReg.dir[gi]),
                .pullBit(stReg.pull[gi]),
                .dataBit(stReg.data[gi]),
                .altEn(altEnVec[gi]),
                .altVal(timerOut),
                .drive(cellDrive[gi]),
                .driveEn(cellOe[gi]),
                .pullEn(cellPu[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin levels as seen by a data read
    // ----------------------------------------------------------------
    // with the external reset option the input-only pin is the reset
    // line, so its data bit is masked to the inactive level
    always_comb
    begin
        pinLevel = pinIn;
        if (extResetSel)
        begin
            pinLevel[gpb_pkg::INPUT_ONLY_PIN] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // low two address bits are ignored, every register is one word
    always_comb
    begin
        dec.kind = gpb_pkg::KIND_NONE;
        dec.port = gpb_pkg::PORT_P0;
        case (paddr[11:2])
            gpb_pkg::IDX_P0_DIR:
            begin
                dec.kind = gpb_pkg::KIND_DIR;
                dec.port = gpb_pkg::PORT_P0;
            end
            gpb_pkg::IDX_P1_DIR:
            begin
                dec.kind = gpb_pkg::KIND_DIR;
                dec.port = gpb_pkg::PORT_P1;
            end
            gpb_pkg::IDX_P2_DIR:
            begin
                dec.kind = gpb_pkg::KIND_DIR;
                dec.port = gpb_pkg::PORT_P2;
            end
            gpb_pkg::IDX_P5_DIR:
            begin
                dec.kind = gpb_pkg::KIND_DIR;
                dec.port = gpb_pkg::PORT_P5;
            end
            gpb_pkg::IDX_P0_DATA:
            begin
                dec.kind = gpb_pkg::KIND_DATA;
                dec.port = gpb_pkg::PORT_P0;
            end
            gpb_pkg::IDX_P1_DATA:
            begin
                dec.kind = gpb_pkg::KIND_DATA;
                dec.port = gpb_pkg::PORT_P1;
            end
            gpb_pkg::IDX_P2_DATA:
            begin
                dec.kind = gpb_pkg::KIND_DATA;
                dec.port = gpb_pkg::PORT_P2;
            end
            gpb_pkg::IDX_P5_DATA:
            begin
                dec.kind = gpb_pkg::KIND_DATA;
                dec.port = gpb_pkg::PORT_P5;
            end
            gpb_pkg::IDX_P0_PULL:
            begin
                dec.kind = gpb_pkg::KIND_PULL;
                dec.port = gpb_pkg::PORT_P0;
            end
            gpb_pkg::IDX_P1_PULL:
            begin
                dec.kind = gpb_pkg::KIND_PULL;
                dec.port = gpb_pkg::PORT_P1;
            end
            gpb_pkg::IDX_P2_PULL:
            begin
                dec.kind = gpb_pkg::KIND_PULL;
                dec.port = gpb_pkg::PORT_P2;
            end
            gpb_pkg::IDX_P5_PULL:
            begin
                dec.kind = gpb_pkg::KIND_PULL;
                dec.port = gpb_pkg::PORT_P5;
            end
            gpb_pkg::IDX_DIR_BITOP:
            begin
                dec.kind = gpb_pkg::KIND_BITOP;
            end
            default:
            begin
                dec.kind = gpb_pkg::KIND_NONE; // unmapped: error answer
            end
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // a request is answered one cycle into the access phase; the write
    // lands on the edge that samples pready high; a master that keeps the
    // request up past that edge is answered again and writes a second time
    always_comb
    begin
        logic [31:0] rdVal;
        logic [2:0] selPin;
        rdVal = gpb_pkg::RDATA_RST;
        selPin = pwdata[gpb_pkg::BITOP_SEL_LSB +: 3];
        stNext = stReg;
        // read value assembled from the pins of the addressed port
        for (int i = 0; i < gpb_pkg::NUM_PINS; i++)
        begin
            if (gpb_pkg::PIN_PORT[i] == dec.port)
            begin
                case (dec.kind)
                    gpb_pkg::KIND_DIR: rdVal[gpb_pkg::PIN_BIT[i]] = stReg.dir[i];
                    gpb_pkg::KIND_DATA: rdVal[gpb_pkg::PIN_BIT[i]] = pinLevel[i];
                    default: rdVal[gpb_pkg::PIN_BIT[i]] = 1'b0; // pull-ups read as zero
                endcase
            end
        end
        if (clkEn)
        begin
            // pin outputs follow the registered controls
            stNext.out = cellDrive;
            stNext.oe = cellOe;
            stNext.pu = cellPu;
            stNext.irqLevel = extIrqEnable & pinIn[gpb_pkg::IRQ_PIN];
            if (accessPhase && !stReg.ready)
            begin
                // first access cycle: present the answer
                stNext.ready = 1'b1;
                stNext.slvErr = (dec.kind == gpb_pkg::KIND_NONE);
                stNext.rdata = pwrite ? gpb_pkg::RDATA_RST : rdVal;
            end
            else
            begin
                // completion edge or idle: drop the answer
                stNext.ready = 1'b0;
                stNext.slvErr = 1'b0;
                stNext.rdata = gpb_pkg::RDATA_RST;
                if (accessPhase && pwrite)
                begin
                    for (int i = 0; i < gpb_pkg::NUM_PINS; i++)
                    begin
                        if (gpb_pkg::PIN_PORT[i] == dec.port)
                        begin
                            case (dec.kind)
                                gpb_pkg::KIND_DIR: stNext.dir[i] = pwdata[gpb_pkg::PIN_BIT[i]];
                                gpb_pkg::KIND_PULL: stNext.pull[i] = pwdata[gpb_pkg::PIN_BIT[i]];
                                gpb_pkg::KIND_DATA: stNext.data[i] = pwdata[gpb_pkg::PIN_BIT[i]];
                                default: stNext.data[i] = stNext.data[i];
                            endcase
                        end
                    end
                    if (dec.kind == gpb_pkg::KIND_BITOP)
                    begin
                        // touches one direction bit, leaves the rest alone
                        stNext.dir[selPin] = pwdata[gpb_pkg::BITOP_VAL_POS];
                    end
                end
            end
            // the input-only pin keeps no control state of its own
            stNext.dir[gpb_pkg::INPUT_ONLY_PIN] = 1'b0;
            stNext.pull[gpb_pkg::INPUT_ONLY_PIN] = 1'b0;
            stNext.data[gpb_pkg::INPUT_ONLY_PIN] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // reset wins over the clock enable so a frozen bank still clears
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            stReg.dir <= gpb_pkg::DIR_RST;
            stReg.pull <= gpb_pkg::PULL_RST;
            stReg.data <= gpb_pkg::DATA_RST;
            stReg.ready <= 1'b0;
            stReg.slvErr <= 1'b0;
            stReg.rdata <= gpb_pkg::RDATA_RST;
            stReg.out <= 8'h00;
            stReg.oe <= 8'h00;
            stReg.pu <= 8'h00;
            stReg.irqLevel <= 1'b0;
        end
        else
        begin
            stReg <= stNext;
        end
    end

    // outputs straight from the state register
    assign prdata = stReg.rdata;
    assign pready = stReg.ready;
    assign pslverr = stReg.slvErr;
    assign pinOut = stReg.out;
    assign pinOe = stReg.oe;
    assign pullupEn = stReg.pu;
    assign extIrqInput = stReg.irqLevel;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // write completing on a given register index
    sequence sWriteDone(logic [9:0] idx);
        psel && penable && pready && pwrite && clkEn && paddr[11:2] == idx;
    endsequence

    // read request entering its first access cycle
    sequence sReadStart(logic [9:0] idx);
        psel && penable && !pready && !pwrite && clkEn && paddr[11:2] == idx;
    endsequence

    a_dir_write: assert property (sWriteDone(gpb_pkg::IDX_P2_DIR) ##1 (clkEn && !altActive)
        |=> pinOe[6:5] == $past(pwdata[1:0], 2))
        else $error("direction write did not reach the pin enables");
    a_pull_write: assert property (sWriteDone(gpb_pkg::IDX_P2_PULL) ##1 (clkEn && stReg.dir[6:5] == 2'h0)
        |=> pullupEn[6:5] == $past(pwdata[1:0], 2))
        else $error("pull-up write did not reach the pull enables");
    a_pull_input: assert property ((pullupEn & pinOe) == 8'h00)
        else $error("pull-up active on a driven pin");
    a_input_only_oe: assert property (clkEn ##1 1'b1 |-> !pinOe[gpb_pkg::INPUT_ONLY_PIN]
        && !stReg.dir[gpb_pkg::INPUT_ONLY_PIN])
        else $error("input-only pin is driven");
    a_input_only_pu: assert property (sWriteDone(gpb_pkg::IDX_P1_PULL)
        |=> !stReg.pull[gpb_pkg::INPUT_ONLY_PIN] ##1 !pullupEn[gpb_pkg::INPUT_ONLY_PIN])
        else $error("input-only pin got a pull-up");
    a_reset_pin_read: assert property (sReadStart(gpb_pkg::IDX_P1_DATA) and extResetSel
        |=> pready && prdata[1])
        else $error("input-only data bit not read as one");
    a_data_read: assert property (sReadStart(gpb_pkg::IDX_P0_DATA)
        |=> pready && !pslverr && prdata == {31'h0000_0000, $past(pinIn[0])})
        else $error("port data read does not show the pin level");
    a_data_drive: assert property (sWriteDone(gpb_pkg::IDX_P1_DATA) ##1 clkEn
        |=> pinOut[4:3] == $past(pwdata[3:2], 2))
        else $error("data write did not reach the pin outputs");
    a_bit_op: assert property (sWriteDone(gpb_pkg::IDX_DIR_BITOP) ##0 (pwdata[2:0] != 3'h2)
        |=> ((stReg.dir ^ $past(stReg.dir)) & ~(8'h01 << $past(pwdata[2:0]))) == 8'h00
        && stReg.dir[$past(pwdata[2:0])] == $past(pwdata[7]))
        else $error("bit operation disturbed other direction bits");
    a_shared_gpio: assert property (clkEn && !pwmOutEnable && !toggleOutEnable
        |=> pinOe[gpb_pkg::ALT_PIN] == $past(stReg.dir[gpb_pkg::ALT_PIN])
        && pinOut[gpb_pkg::ALT_PIN] == $past(stReg.data[gpb_pkg::ALT_PIN]))
        else $error("shared pin not acting as plain gpio");
    a_reset_clear: assert property ($past(reset) |-> stReg.dir == 8'h00 && stReg.pull == 8'h00
        && stReg.data == 8'h00 && pinOe == 8'h00 && pullupEn == 8'h00)
        else $error("reset left control bits set");

endmodule

// >>> tb.sv
// self-checking bench for the general-purpose port bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1; // kept running: freezing is not exercised here
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, extIrqInput;
    logic [7:0] pinIn, pinOut, pinOe, pullupEn;
    logic [7:0] extDrv = 8'h00, extEn = 8'hff; // board drives every pin the port leaves free
    logic extResetSel = 1'b0, extIrqEnable = 1'b0, counterEnable = 1'b0;
    logic toggleOutEnable = 1'b0, pwmOutEnable = 1'b0, timerOut = 1'b0;
    logic [32:0] expQ[$]; // expected {pslverr, prdata} of each read, oldest first
    int n_errors = 0;
    int checks_done = 0;
    logic [31:0] rng = 32'h0001_3167; // xorshift seed, 78183
    logic [7:0] oe, out, lvl;
    logic [9:0] dirIdx[4] = '{gpb_pkg::IDX_P0_DIR, gpb_pkg::IDX_P1_DIR, gpb_pkg::IDX_P2_DIR, gpb_pkg::IDX_P5_DIR};
    logic [9:0] dataIdx[4] = '{gpb_pkg::IDX_P0_DATA, gpb_pkg::IDX_P1_DATA, gpb_pkg::IDX_P2_DATA,
                               gpb_pkg::IDX_P5_DATA};
    logic [9:0] pullIdx[4] = '{gpb_pkg::IDX_P0_PULL, gpb_pkg::IDX_P1_PULL, gpb_pkg::IDX_P2_PULL,
                               gpb_pkg::IDX_P5_PULL};
    logic [7:0] dirMask[4] = '{8'h01, 8'h0d, 8'h03, 8'h10}; // implemented direction bits

    initial forever #4 ref_clk = ~ref_clk;

    gpb_port_bank gpb_port_bank_inst (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pullupEn(pullupEn), .extResetSel(extResetSel), .extIrqEnable(extIrqEnable),
        .extIrqInput(extIrqInput), .counterEnable(counterEnable), .toggleOutEnable(toggleOutEnable),
        .pwmOutEnable(pwmOutEnable), .timerOut(timerOut));

    gpb_board_model gpb_board_model_inst (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
        .pullupEn(pullupEn), .extDrv(extDrv), .extEn(extEn), .pinIn(pinIn));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // gathers the pins of one port into its register bit positions
    function automatic logic [7:0] portOf(input logic [7:0] pv, input logic [1:0] prt);
        portOf = 8'h00;
        for (int i = 0; i < 8; i++)
            if (gpb_pkg::PIN_PORT[i] == prt)
                portOf[gpb_pkg::PIN_BIT[i]] = pv[i];
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; pready is sampled at each rising edge, and the request
    // is released at the very edge that sees it high, never later
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            n_errors++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [32:0] exp);
        expQ.push_back(exp);
        apb(1'b0, idx, 32'h0);
    endtask

    // pins settle one edge after the register update; three edges is safe margin
    task automatic pins(input logic [7:0] eOe, input logic [7:0] eOut, input logic [7:0] ePu);
        repeat (3) @(posedge ref_clk);
        check("pinOe", pinOe, eOe);
        check("pinOut", pinOut & eOe, eOut & eOe);
        check("pullupEn", pullupEn, ePu);
    endtask

    // read answers are taken at the rising edge that samples pready high
    always @(posedge ref_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (expQ.size() == 0)
                check("stray read", 33'h0, 33'h1);
            else
                check("read answer", {pslverr, prdata}, expQ.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        pins(8'h00, 8'h00, 8'h00);
        for (int p = 0; p < 4; p++)
        begin
            rd(dirIdx[p], 33'h0);
            rd(dataIdx[p], 33'h0);
            apb(1'b1, dirIdx[p], 32'hffff_ffff);
            rd(dirIdx[p], {25'h0, dirMask[p]});
            apb(1'b1, pullIdx[p], 32'hffff_ffff);
            rd(pullIdx[p], 33'h0);
        end
        pins(8'hfb, 8'h00, 8'h00);
        apb(1'b1, pullIdx[1], 32'h0);
        for (int p = 0; p < 4; p++)
            apb(1'b1, dirIdx[p], 32'h0);
        pins(8'h00, 8'h00, 8'he1);
        // random directions, latches and board levels
        repeat (6)
        begin
            rng = xs(rng);
            extDrv <= rng[15:8];
            extResetSel <= rng[16];
            for (int p = 0; p < 4; p++)
            begin
                apb(1'b1, dirIdx[p], {24'h0, rng[7:0]});
                apb(1'b1, dataIdx[p], {24'h0, rng[31:24]});
            end
            for (int i = 0; i < 8; i++)
            begin
                oe[i] = rng[gpb_pkg::PIN_BIT[i]] && i != gpb_pkg::INPUT_ONLY_PIN;
                out[i] = rng[24 + gpb_pkg::PIN_BIT[i]];
            end
            lvl = (oe & out) | (~oe & rng[15:8]);
            lvl[2] = lvl[2] | rng[16];
            pins(oe, out, ~oe & 8'he1);
            for (int p = 0; p < 4; p++)
                rd(dataIdx[p], {25'h0, portOf(lvl, p[1:0])});
        end
        // single-bit direction set on every pin, then clear
        for (int p = 0; p < 4; p++)
            apb(1'b1, dirIdx[p], 32'h0);
        oe = 8'h00;
        for (int k = 0; k < 16; k++)
        begin
            apb(1'b1, gpb_pkg::IDX_DIR_BITOP, {24'h0, k < 8, 4'h0, k[2:0]});
            oe[k % 8] = (k < 8) && (k % 8 != gpb_pkg::INPUT_ONLY_PIN);
            pins(oe, out, ~oe & 8'he1);
        end
        rd(10'h3ff, {1'b1, 32'h0});
        // shared pin: every timer enable combination
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, dirIdx[p], 32'hff);
            apb(1'b1, dataIdx[p], 32'h0);
        end
        for (int k = 0; k < 8; k++)
        begin
            rng = xs(rng);
            {pwmOutEnable, counterEnable, toggleOutEnable, timerOut} <= {k[2:0], rng[0]};
            out = {(k[2] | (k[1] & k[0])) & rng[0], 7'h0};
            pins(8'hfb, out, 8'h00);
        end
        // reset in mid-run with control bits set: every one must clear
        reset <= 1'b1;
        {pwmOutEnable, counterEnable, toggleOutEnable} <= 3'h0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        pins(8'h00, 8'h00, 8'h00);
        rd(dirIdx[3], 33'h0);
        // interrupt input gating on pin 0
        apb(1'b1, dirIdx[0], 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            {extIrqEnable, extDrv[0]} <= k[1:0];
            repeat (3) @(posedge ref_clk);
            check("extIrqInput", extIrqInput, k[1] & k[0]);
        end
        check("pending reads", 33'(expQ.size()), 33'h0);
        end_of_test();
    end
endmodule
